// ===== common/fault_log_defs.svh
`ifndef FAULT_LOG_DEFS_SVH
`define FAULT_LOG_DEFS_SVH

// ==========================================================================
// Log image geometry
`define LOG_IMAGE_BYTES   8'd147
`define LOG_LAST_BYTE     8'd146
`define HDR_BYTES         8'd27
`define REC_BYTES         8'd20
`define REC_LAST_IDX      5'd19
`define REC_IN_IMAGE      5
`define RING_SLOTS        4'd7
`define RING_LAST_SLOT    3'd6
`define RING_DEPTH        140

// ==========================================================================
// Header field positions (byte index within the image)
`define HDR_CAUSE_BYTE    4
`define HDR_TEMP_LO_BYTE  21
`define HDR_TEMP_HI_BYTE  26

// ==========================================================================
// Values
// Preface bytes 0..3, byte 0 in the low lane; identifier value is arbitrary
`define LOG_PREFACE       32'h5AA54C46
`define FORCED_STORE_CODE 8'hFF
`define NO_LOG_COUNT      8'h00
`define PAD_BYTE          8'hFF
`define ERASE_BYTE        8'h00

// ==========================================================================
// Die temperature thresholds in degrees C
`define TEMP_HOLD_C       9'd130
`define TEMP_RELEASE_C    9'd125

`endif

// ===== common/fault_log_pkg.sv
package fault_log_pkg;

  // ========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_LOAD,
    ST_RECORD,
    ST_FINISH,
    ST_HOT_WAIT,
    ST_COPY_RD,
    ST_COPY_WR,
    ST_FROZEN,
    ST_ERASE
  } log_state_e;

  // Kind of byte answered on the block read
  typedef enum logic [1:0] {
    ANS_COUNT,
    ANS_DATA,
    ANS_PAD
  } answer_kind_e;

endpackage

// ===== rtl/fault_log_ram.sv
`timescale 1ns/100ps
`include "fault_log_defs.svh"

// ==========================================================================
// Ring of event records, one write port and a registered read port
module fault_log_ram (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_wr_en,
  input  wire logic [7:0] i_wr_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic [7:0] i_rd_addr,
  output logic      [7:0] o_rd_data
);

  logic [7:0] mem_q [0:`RING_DEPTH-1];

  // Storage itself is not reset, like a real RAM macro
  always_ff @(posedge i_clock) begin
    if (i_wr_en) begin
      mem_q[i_wr_addr] <= i_wr_data;
    end
  end

  // Read data leaves from a register; read every cycle
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= mem_q[i_rd_addr];
    end
  end

endmodule

// ===== rtl/fault_log_recorder.sv
`timescale 1ns/100ps
`include "fault_log_defs.svh"

module fault_log_recorder import fault_log_pkg::*; (
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // Record bytes from the monitor sequencer
  input  wire logic        i_rec_byte_valid,
  input  wire logic [4:0]  i_rec_byte_idx,
  input  wire logic [7:0]  i_rec_byte,
  input  wire logic        i_cycle_done,
  input  wire logic [3:0]  i_adc_input,
  // Fault events
  input  wire logic        i_chan_fault_valid,
  input  wire logic [7:0]  i_chan_fault_code,
  input  wire logic        i_fault_external,
  input  wire logic        i_forced_log_store_cmd,
  input  wire logic        i_clear_faults_cmd,
  input  wire logic        i_log_erase_cmd,
  input  wire logic        i_memory_fault,
  input  wire logic [8:0]  i_die_temp_c,
  // Header sources
  input  wire logic [47:0] i_share_clock_timestamp,
  input  wire logic [15:0] i_peak_output_voltage0,
  input  wire logic [15:0] i_peak_output_voltage1,
  input  wire logic [15:0] i_peak_output_current0,
  input  wire logic [15:0] i_peak_output_current1,
  input  wire logic [15:0] i_peak_input_voltage,
  input  wire logic [15:0] i_temp_ext0,
  input  wire logic [15:0] i_temp_ext1,
  input  wire logic [15:0] i_temp_int,
  // Block read of the log image
  input  wire logic        i_rd_start,
  input  wire logic        i_rd_next,
  output logic      [7:0]  o_rd_data,
  output logic             o_rd_valid,
  // Non-volatile memory port
  output logic             o_nvm_req,
  output logic             o_nvm_we,
  output logic      [7:0]  o_nvm_addr,
  output logic      [7:0]  o_nvm_wdata,
  input  wire logic        i_nvm_ack,
  input  wire logic [7:0]  i_nvm_rdata,
  // Status
  output logic             o_valid_log_flag,
  output logic             o_log_present,
  output logic             o_logging_enabled,
  output logic             o_partial_log,
  output logic      [3:0]  o_fault_adc_input
);

  // ========================================================================
  // Image byte pointer to ring address
  // Record r of the image sits r slots behind the fault slot
  function automatic logic [7:0] ring_addr(input logic [7:0] ptr, input logic [2:0] fslot);
    logic [7:0] off;
    logic [3:0] slot_w;
    logic [2:0] rec;
    off    = ptr - `HDR_BYTES;
    rec    = 3'd0;
    slot_w = 4'd0;
    for (int k = 0; k < `REC_IN_IMAGE; k++) begin
      if (off >= `REC_BYTES) begin
        off = off - `REC_BYTES;
        rec = rec + 3'd1;
      end
    end
    slot_w = {1'b0, fslot} + `RING_SLOTS - {1'b0, rec};
    if (slot_w >= `RING_SLOTS) begin
      slot_w = slot_w - `RING_SLOTS;
    end
    ring_addr = {5'b00000, slot_w[2:0]} * `REC_BYTES + off;
  endfunction

  // ========================================================================
  // State
  log_state_e        state_q;
  answer_kind_e      ans_kind_q;
  logic [26:0][7:0]  hdr_q;
  logic [26:0][7:0]  hdr_cap;
  logic [2:0]        wr_slot_q;
  logic [2:0]        fault_slot_q;
  logic [7:0]        load_ptr_q;
  logic [7:0]        copy_ptr_q;
  logic [7:0]        host_ptr_q;
  logic              count_phase_q;
  logic              hot_q;
  logic              hdr_sel_q;
  logic [7:0]        hdr_byte_q;
  logic [7:0]        ans_byte_q;
  logic              ans_valid_q;
  logic [7:0]        ram_rdata;

  // ========================================================================
  // Decodes
  wire        recording    = (state_q == ST_RECORD) || (state_q == ST_FINISH);
  wire        fault_trig   = (i_chan_fault_valid && !i_fault_external) || i_forced_log_store_cmd;
  wire [7:0]  fault_cause  = i_forced_log_store_cmd ? `FORCED_STORE_CODE : i_chan_fault_code;
  wire        rec_we       = recording && i_rec_byte_valid && (i_rec_byte_idx <= `REC_LAST_IDX);
  wire [7:0]  rec_addr     = {5'b00000, wr_slot_q} * `REC_BYTES + {3'b000, i_rec_byte_idx};
  wire        load_hit     = (state_q == ST_LOAD) && o_nvm_req && i_nvm_ack;
  wire        load_is_hdr  = load_ptr_q < `HDR_BYTES;
  wire        load_we      = load_hit && !load_is_hdr;
  wire        ram_we       = rec_we || load_we;
  wire [7:0]  ram_waddr    = load_we ? ring_addr(load_ptr_q, `RING_LAST_SLOT) : rec_addr;
  wire [7:0]  ram_wdata    = load_we ? i_nvm_rdata : i_rec_byte;
  wire        preface_ok   = (hdr_q[3:0] == `LOG_PREFACE);
  wire        host_rd_now  = i_rd_next && !i_rd_start && !count_phase_q && o_log_present
                             && (host_ptr_q <= `LOG_LAST_BYTE);
  wire        copy_rd_now  = (state_q == ST_COPY_RD) && !host_rd_now;
  wire [7:0]  rp_ptr       = host_rd_now ? host_ptr_q : copy_ptr_q;
  wire [7:0]  rp_addr      = ring_addr(rp_ptr, fault_slot_q);
  wire [7:0]  rd_byte      = hdr_sel_q ? hdr_byte_q : ram_rdata;
  wire        nvm_done     = o_nvm_req && i_nvm_ack;
  wire        slot_wrap    = (wr_slot_q == `RING_LAST_SLOT);
  wire        go_record    = (state_q == ST_FROZEN) && i_clear_faults_cmd && !o_partial_log;
  wire        go_erase     = ((state_q == ST_FROZEN) || (state_q == ST_RECORD)) && i_log_erase_cmd;

  // Header as captured at the fault; byte 0 sits in the low lane
  assign hdr_cap = {i_temp_int[7:0], i_temp_int[15:8],
                    i_temp_ext1[7:0], i_temp_ext1[15:8],
                    i_temp_ext0[7:0], i_temp_ext0[15:8],
                    i_peak_input_voltage[7:0], i_peak_input_voltage[15:8],
                    i_peak_output_current1[7:0], i_peak_output_current1[15:8],
                    i_peak_output_current0[7:0], i_peak_output_current0[15:8],
                    i_peak_output_voltage1[7:0], i_peak_output_voltage1[15:8],
                    i_peak_output_voltage0[7:0], i_peak_output_voltage0[15:8],
                    i_share_clock_timestamp,
                    fault_cause,
                    `LOG_PREFACE};

  // ========================================================================
  // Record ring
  fault_log_ram u_ram (
    .i_clock   (i_clock),
    .i_rst_b   (i_rst_b),
    .i_wr_en   (ram_we),
    .i_wr_addr (ram_waddr),
    .i_wr_data (ram_wdata),
    .i_rd_addr (rp_addr),
    .o_rd_data (ram_rdata)
  );

  // Write slot steps once per completed ADC pass; the fault pass is not advanced
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_slot_q <= 3'd0;
    end else if ((state_q == ST_RECORD) && i_cycle_done && !fault_trig) begin
      wr_slot_q <= slot_wrap ? 3'd0 : wr_slot_q + 3'd1;
    end
  end

  // Die temperature hysteresis for the NVM write
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hot_q <= 1'b0;
    end else if (i_die_temp_c > `TEMP_HOLD_C) begin
      hot_q <= 1'b1;
    end else if (i_die_temp_c < `TEMP_RELEASE_C) begin
      hot_q <= 1'b0;
    end
  end

  // ========================================================================
  // Header store: whole header at the fault, temperatures when the pass ends
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hdr_q <= '0;
    end else if ((state_q == ST_RECORD) && fault_trig) begin
      hdr_q <= hdr_cap;
    end else if ((state_q == ST_FINISH) && i_cycle_done) begin
      hdr_q[`HDR_TEMP_HI_BYTE:`HDR_TEMP_LO_BYTE] <= hdr_cap[`HDR_TEMP_HI_BYTE:`HDR_TEMP_LO_BYTE];
    end else if (load_hit && load_is_hdr) begin
      hdr_q[load_ptr_q[4:0]] <= i_nvm_rdata;
    end
  end

  // Shared read port: header bytes come from registers, records from the ring
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hdr_sel_q  <= 1'b0;
      hdr_byte_q <= 8'h00;
    end else begin
      hdr_sel_q  <= rp_ptr < `HDR_BYTES;
      hdr_byte_q <= (rp_ptr < `HDR_BYTES) ? hdr_q[rp_ptr[4:0]] : 8'h00;
    end
  end

  // ========================================================================
  // Block read: count byte first, then image bytes, then pad bytes
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_phase_q <= 1'b0;
      host_ptr_q    <= 8'd0;
    end else if (i_rd_start) begin
      count_phase_q <= 1'b1;
      host_ptr_q    <= 8'd0;
    end else if (i_rd_next && count_phase_q) begin
      count_phase_q <= 1'b0;
    end else if (host_rd_now) begin
      host_ptr_q    <= host_ptr_q + 8'd1;
    end
  end

  // First answer stage remembers what kind of byte is owed
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ans_valid_q <= 1'b0;
      ans_kind_q  <= ANS_PAD;
      ans_byte_q  <= `PAD_BYTE;
    end else begin
      ans_valid_q <= i_rd_next && !i_rd_start;
      ans_kind_q  <= count_phase_q ? ANS_COUNT : (host_rd_now ? ANS_DATA : ANS_PAD);
      ans_byte_q  <= o_log_present ? `LOG_IMAGE_BYTES : `NO_LOG_COUNT;
    end
  end

  // Output stage
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_valid <= 1'b0;
      o_rd_data  <= 8'h00;
    end else begin
      o_rd_valid <= ans_valid_q;
      unique case (ans_kind_q)
        ANS_COUNT: o_rd_data <= ans_byte_q;
        ANS_DATA:  o_rd_data <= rd_byte;
        ANS_PAD:   o_rd_data <= `PAD_BYTE;
        default:   o_rd_data <= `PAD_BYTE;
      endcase
    end
  end

  // ========================================================================
  // Sequencer: power-up load, recording, capture, NVM copy, erase
  // Clear-faults and erase are ignored while a capture or copy is running,
  // so a stored image is never left half written by a command.
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_q           <= ST_LOAD;
      load_ptr_q        <= 8'd0;
      copy_ptr_q        <= 8'd0;
      fault_slot_q      <= 3'd0;
      o_nvm_req         <= 1'b0;
      o_nvm_we          <= 1'b0;
      o_nvm_addr        <= 8'd0;
      o_nvm_wdata       <= 8'h00;
      o_valid_log_flag  <= 1'b0;
      o_log_present     <= 1'b0;
      o_partial_log     <= 1'b0;
      o_fault_adc_input <= 4'd0;
    end else begin
      unique case (state_q)
        // Read the stored image back into header and ring
        ST_LOAD: begin
          if (!o_nvm_req) begin
            o_nvm_req  <= 1'b1;
            o_nvm_we   <= 1'b0;
            o_nvm_addr <= load_ptr_q;
          end else if (i_nvm_ack) begin
            o_nvm_req <= 1'b0;
            if (load_ptr_q == `LOG_LAST_BYTE) begin
              fault_slot_q <= `RING_LAST_SLOT;
              if (preface_ok) begin
                o_valid_log_flag <= 1'b1;
                o_log_present    <= 1'b1;
                o_partial_log    <= i_memory_fault;
                state_q          <= ST_FROZEN;
              end else begin
                state_q <= ST_RECORD;
              end
            end else begin
              load_ptr_q <= load_ptr_q + 8'd1;
            end
          end
        end
        ST_RECORD: begin
          if (fault_trig) begin
            o_fault_adc_input <= i_adc_input;
            state_q           <= ST_FINISH;
          end else if (go_erase) begin
            state_q <= ST_ERASE;
          end
        end
        // Complete the pass in progress, then freeze
        ST_FINISH: begin
          if (i_cycle_done) begin
            fault_slot_q  <= wr_slot_q;
            o_log_present <= 1'b1;
            state_q       <= ST_HOT_WAIT;
          end
        end
        ST_HOT_WAIT: begin
          copy_ptr_q <= 8'd0;
          if (!hot_q) begin
            state_q <= ST_COPY_RD;
          end
        end
        // Host reads win the port; the copy waits a cycle for each host read taken
        ST_COPY_RD: begin
          if (copy_rd_now) begin
            state_q <= ST_COPY_WR;
          end
        end
        ST_COPY_WR: begin
          if (!o_nvm_req) begin
            o_nvm_req   <= 1'b1;
            o_nvm_we    <= 1'b1;
            o_nvm_addr  <= copy_ptr_q;
            o_nvm_wdata <= rd_byte;
          end else if (i_nvm_ack) begin
            o_nvm_req <= 1'b0;
            if (copy_ptr_q == `LOG_LAST_BYTE) begin
              state_q <= ST_FROZEN;
            end else begin
              copy_ptr_q <= copy_ptr_q + 8'd1;
              state_q    <= ST_COPY_RD;
            end
          end
        end
        // Log held for reading; a full log resumes on clear-faults
        ST_FROZEN: begin
          if (go_erase) begin
            state_q <= ST_ERASE;
          end else if (go_record) begin
            o_log_present <= 1'b0;
            state_q       <= ST_RECORD;
          end
        end
        // Spoil the stored preface so power-up finds no log
        ST_ERASE: begin
          if (!o_nvm_req) begin
            o_nvm_req   <= 1'b1;
            o_nvm_we    <= 1'b1;
            o_nvm_addr  <= 8'd0;
            o_nvm_wdata <= `ERASE_BYTE;
          end else if (nvm_done) begin
            o_nvm_req        <= 1'b0;
            o_valid_log_flag <= 1'b0;
            o_log_present    <= 1'b0;
            o_partial_log    <= 1'b0;
            state_q          <= ST_RECORD;
          end
        end
      endcase
    end
  end

  // Logging flag falls on the freezing edge, so it never overlaps a held log
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_logging_enabled <= 1'b0;
    end else begin
      o_logging_enabled <= recording && !((state_q == ST_FINISH) && i_cycle_done);
    end
  end

endmodule

// ===== testbench/fault_log_recorder_chk.sv
`timescale 1ns/100ps

// ==========================================================================
// Port-level checks on the fault log recorder
module fault_log_recorder_chk (
  input wire logic       i_clock,
  input wire logic       i_rst_b,
  input wire logic       i_rd_start,
  input wire logic       i_rd_next,
  input wire logic [7:0] o_rd_data,
  input wire logic       o_rd_valid,
  input wire logic       o_nvm_req,
  input wire logic       o_nvm_we,
  input wire logic [7:0] o_nvm_addr,
  input wire logic [7:0] o_nvm_wdata,
  input wire logic       i_nvm_ack,
  input wire logic       i_chan_fault_valid,
  input wire logic       i_fault_external,
  input wire logic       i_forced_log_store_cmd,
  input wire logic       i_cycle_done,
  input wire logic       o_log_present,
  input wire logic       o_logging_enabled,
  input wire logic       o_valid_log_flag,
  input wire logic       o_partial_log
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);

  // Every taken byte request is answered exactly two edges later
  property p_rd_answer; i_rd_next && !i_rd_start |-> ##2 o_rd_valid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read answer missing");
  property p_rd_single; o_rd_valid |-> $past(i_rd_next, 2) && !$past(i_rd_start, 2); endproperty
  a_rd_single: assert property (p_rd_single) else $error("read answer without request");
  // First answer of a block read is the fixed count or zero
  property p_rd_count;
    i_rd_start ##1 (i_rd_next && !i_rd_start) |-> ##2 (o_rd_data == (o_log_present ? 8'h93 : 8'h00));
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("block count wrong");
  // Memory requests stand still until acknowledged, then drop
  property p_nvm_hold;
    o_nvm_req && !i_nvm_ack |=> o_nvm_req && $stable(o_nvm_addr) && $stable(o_nvm_we) && $stable(o_nvm_wdata);
  endproperty
  a_nvm_hold: assert property (p_nvm_hold) else $error("memory request changed early");
  property p_nvm_release; o_nvm_req && i_nvm_ack |=> !o_nvm_req; endproperty
  a_nvm_release: assert property (p_nvm_release) else $error("memory request not released");
  // Pin-borne faults never freeze the log
  property p_ext_ignored;
    i_chan_fault_valid && i_fault_external && !i_forced_log_store_cmd && !i_cycle_done && o_logging_enabled
      && !o_log_present |=> !o_log_present;
  endproperty
  a_ext_ignored: assert property (p_ext_ignored) else $error("external fault made a log");
  // A live log appears only when the ADC pass closes
  property p_freeze_on_pass; $rose(o_log_present) && !o_valid_log_flag |-> $past(i_cycle_done); endproperty
  a_freeze_on_pass: assert property (p_freeze_on_pass) else $error("log frozen mid pass");
  property p_exclusive; o_log_present |-> !o_logging_enabled; endproperty
  a_exclusive: assert property (p_exclusive) else $error("recording while log held");
  property p_partial; o_partial_log |-> o_valid_log_flag && !o_logging_enabled; endproperty
  a_partial: assert property (p_partial) else $error("partial log allowed recording");
endmodule

bind fault_log_recorder fault_log_recorder_chk fault_log_recorder_chk_i (.*);

// ===== testbench/nvm_model.sv
`timescale 1ns/100ps

// ==========================================================================
// Byte-wide non-volatile store with a programmable answer stall
module nvm_model (
  input  wire logic       i_clock,
  input  wire logic       i_req,
  input  wire logic       i_we,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [1:0] i_delay,
  output logic            o_ack,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [0:146];
  logic [1:0] wait_q;

  initial begin
    o_ack = 1'b0;
    o_rdata = 8'h00;
    wait_q = 2'h0;
  end

  // Read data toggles when not acknowledged, so a stale sample never matches
  always @(posedge i_clock) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (wait_q == i_delay) begin
        o_ack <= 1'b1;
        wait_q <= 2'h0;
        if (i_we) begin
          mem[i_addr] <= i_wdata;
        end else begin
          o_rdata <= mem[i_addr];
        end
      end else begin
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule

// ===== testbench/tb.sv
`timescale 1ns/100ps

module tb;
  // ==========================================================================
  // Design connections and bench state
  logic        i_clock, i_rst_b, i_rec_byte_valid, i_cycle_done, i_chan_fault_valid, i_fault_external;
  logic        i_forced_log_store_cmd, i_clear_faults_cmd, i_log_erase_cmd, i_memory_fault, i_rd_start;
  logic        i_rd_next, i_nvm_ack, o_rd_valid, o_nvm_req, o_nvm_we, o_valid_log_flag, o_log_present;
  logic        o_logging_enabled, o_partial_log;
  logic [4:0]  i_rec_byte_idx;
  logic [7:0]  i_rec_byte, i_chan_fault_code, i_nvm_rdata, o_rd_data, o_nvm_addr, o_nvm_wdata;
  logic [3:0]  i_adc_input, o_fault_adc_input;
  logic [8:0]  i_die_temp_c;
  logic [47:0] i_share_clock_timestamp;
  logic [15:0] i_peak_output_voltage0, i_peak_output_voltage1, i_peak_output_current0;
  logic [15:0] i_peak_output_current1, i_peak_input_voltage, i_temp_ext0, i_temp_ext1, i_temp_int;
  logic [1:0]  nvm_delay;
  logic [191:0] hv;
  int          errors, check_count, seed, wr_cnt;
  logic [7:0]  img [0:146];
  logic [7:0]  recs [0:7][0:19];
  logic [7:0]  rx [$];
  logic [7:0]  codes [0:16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h0A, 8'h10, 8'h11, 8'h12,
                                8'h13, 8'h15, 8'h16, 8'h17, 8'h1A, 8'hFF};

  fault_log_recorder fault_log_recorder_i (.*);
  nvm_model nvm_model_i (.i_clock(i_clock), .i_req(o_nvm_req), .i_we(o_nvm_we), .i_addr(o_nvm_addr),
    .i_wdata(o_nvm_wdata), .i_delay(nvm_delay), .o_ack(i_nvm_ack), .o_rdata(i_nvm_rdata));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  // Collect read answers and completed memory writes
  always @(posedge i_clock) begin
    if (o_rd_valid === 1'b1) rx.push_back(o_rd_data);
    if (o_nvm_req && o_nvm_we && i_nvm_ack) wr_cnt++;
  end

  // ==========================================================================
  // Bench tasks
  task automatic step(input int n);
    repeat (n) @(negedge i_clock);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask

  task automatic wait_for(ref logic s, input int lim);
    int n = 0;
    while (s !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic reset_dut;
    i_rst_b = 1'b0;
    step(8);
    i_rst_b = 1'b1;
  endtask

  task automatic send_bytes(input int r, input int lo, input int hi);
    for (int k = lo; k <= hi; k++) begin
      i_rec_byte_valid = 1'b1;
      i_rec_byte_idx = 5'(k);
      i_rec_byte = recs[r][k];
      step(1);
    end
    i_rec_byte_valid = 1'b0;
  endtask

  // Start, then n byte requests back to back; drain the last answers
  task automatic read_block(input int n);
    rx.delete();
    i_rd_start = 1'b1;
    step(1);
    i_rd_start = 1'b0;
    repeat (n) begin
      i_rd_next = 1'b1;
      step(1);
    end
    i_rd_next = 1'b0;
    step(3);
  endtask

  // Expected image from the header sources and the record history
  function automatic void build_img(input logic [7:0] code, input int fr);
    img[0] = 8'h46;
    img[1] = 8'h4C;
    img[2] = 8'hA5;
    img[3] = 8'h5A;
    img[4] = code;
    for (int k = 0; k < 6; k++) img[5 + k] = i_share_clock_timestamp[8 * k +: 8];
    for (int k = 0; k < 16; k++) img[11 + k] = hv[127 - 8 * k -: 8];
    for (int r = 0; r < 6; r++) for (int k = 0; k < 20; k++) img[27 + 20 * r + k] = recs[fr - r][k];
  endfunction

  initial begin
    #1600000;
    errors++;
    $display("ERROR watchdog expected finish seen hang");
    results();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    seed = 60167;
    {i_rst_b, i_rec_byte_valid, i_cycle_done, i_chan_fault_valid, i_fault_external, i_rd_next} = '0;
    {i_forced_log_store_cmd, i_clear_faults_cmd, i_log_erase_cmd, i_memory_fault, i_rd_start} = '0;
    {i_rec_byte_idx, i_rec_byte, i_chan_fault_code, i_adc_input, nvm_delay} = '0;
    i_die_temp_c = 9'd40;
    hv = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
    {i_peak_output_voltage0, i_peak_output_voltage1, i_peak_output_current0, i_peak_output_current1} = hv[127:64];
    {i_peak_input_voltage, i_temp_ext0, i_temp_ext1, i_temp_int} = hv[63:0];
    i_share_clock_timestamp = hv[175:128];
    for (int k = 0; k < 147; k++) nvm_model_i.mem[k] = 8'h00;
    for (int r = 0; r < 8; r++) for (int k = 0; k < 20; k++) recs[r][k] = 8'($random(seed));
    reset_dut();
    wait_for(o_logging_enabled, 3000);
    check("logging after blank load", o_logging_enabled, 1'b1);
    check("valid flag blank", o_valid_log_flag, 1'b0);
    read_block(2);
    check("count without log", rx[0], 8'h00);
    check("data without log", rx[1], 8'hFF);
    for (int r = 0; r < 7; r++) begin
      if (r == 3) begin
        i_fault_external = 1'b1;
        pulse(i_chan_fault_valid);
        i_fault_external = 1'b0;
      end
      send_bytes(r, 0, 19);
      pulse(i_cycle_done);
    end
    check("external fault ignored", o_log_present, 1'b0);
    // Fault mid record while the die is hot
    i_die_temp_c = 9'd140;
    i_adc_input = 4'($random(seed));
    i_chan_fault_code = codes[4'($random(seed))];
    send_bytes(7, 0, 9);
    pulse(i_chan_fault_valid);
    send_bytes(7, 10, 19);
    pulse(i_cycle_done);
    step(2);
    check("frozen", o_log_present, 1'b1);
    check("adc input at fault", {4'h0, o_fault_adc_input}, {4'h0, i_adc_input});
    step(60);
    i_die_temp_c = 9'd127;
    step(60);
    check("writes while hot", 8'(wr_cnt), 8'h00);
    i_die_temp_c = 9'd100;
    build_img(i_chan_fault_code, 7);
    read_block(149);
    check("count", rx[0], 8'h93);
    for (int k = 0; k < 147; k++) check("image byte", rx[k + 1], img[k]);
    check("preface", rx[1], 8'h46);
    check("cause", rx[5], i_chan_fault_code);
    check("stamp low", rx[6], i_share_clock_timestamp[7:0]);
    check("peak high", rx[12], i_peak_output_voltage0[15:8]);
    check("temp high", rx[22], i_temp_ext0[15:8]);
    check("record status", rx[40], recs[7][12]);
    check("newest older", rx[48], recs[6][0]);
    check("oldest end", rx[147], recs[2][19]);
    check("pad after image", rx[148], 8'hFF);
    for (int n = 0; n < 3000 && wr_cnt < 147; n++) step(1);
    check("copy count", 8'(wr_cnt), 8'd147);
    for (int k = 0; k < 147; k++) check("stored byte", nvm_model_i.mem[k], img[k]);
    // Power-up on a stored partial log
    i_memory_fault = 1'b1;
    nvm_delay = 2'h1;
    reset_dut();
    wait_for(o_log_present, 3000);
    i_memory_fault = 1'b0;
    check("valid flag", o_valid_log_flag, 1'b1);
    check("partial", o_partial_log, 1'b1);
    read_block(148);
    for (int k = 0; k < 147; k++) check("reloaded byte", rx[k + 1], img[k]);
    pulse(i_clear_faults_cmd);
    step(3);
    check("partial blocks logging", o_logging_enabled, 1'b0);
    pulse(i_log_erase_cmd);
    wait_for(o_logging_enabled, 200);
    check("erase byte", nvm_model_i.mem[0], 8'h00);
    check("valid flag erased", o_valid_log_flag, 1'b0);
    // Every cause code, prompt and slow memory
    for (int i = 0; i < 17; i++) begin
      nvm_delay = 2'($random(seed));
      i_chan_fault_code = codes[i];
      if (codes[i] == 8'hFF) pulse(i_forced_log_store_cmd);
      else pulse(i_chan_fault_valid);
      pulse(i_cycle_done);
      step(2);
      read_block(6);
      check("fault cause", rx[5], codes[i]);
      step(1100); // Slowest copy takes seven cycles a byte
      pulse(i_clear_faults_cmd);
      step(2);
      check("resume after clear", o_logging_enabled, 1'b1);
    end
    results();
  end
endmodule
